// File: dv/rdmr_pipe_model.sv
`timescale 1ns/1ps
// ========================================
// Ingress pipeline side: issues one lookup per request.
module rdmr_pipe_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic [47:0] req_addr,
  input wire logic [3:0] req_port,
  output logic lookup_valid,
  output logic [47:0] dest_addr,
  output logic [3:0] src_port
);
  // Idle lines toggle so that a stale address can never match by luck.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lookup_valid <= 1'b0;
      dest_addr <= 48'h0;
      src_port <= 4'h0;
    end else begin
      lookup_valid <= req;
      dest_addr <= req ? req_addr : ~dest_addr;
      src_port <= req ? req_port : ~src_port;
    end
  end
endmodule : rdmr_pipe_model

// File: dv/rdmr_range_check_test.sv
`timescale 1ns/1ps
// ========================================
// Bench: register tasks, lookup stream, result monitor.
module rdmr_range_check_test;
  import rdmr_pkg::*;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, req = 0, rd_d = 0;
  logic [19:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [47:0] req_addr = '0, dest_addr;
  logic [3:0] req_port = '0, src_port, meter_pointer;
  logic lookup_valid, verdict_valid, discard, redirect_to_host, irq;
  logic queue_override_flag, color_override_flag, meter_pointer_valid;
  logic [2:0] queue_override_value;
  logic [1:0] color, meter_pointer_order, ev = 2'h0;
  logic [127:0] tbl [4];
  logic [15:0] vq [$];
  logic [31:0] rq [$];
  int bad_count = 0, cmp_count = 0, cyc = 0, ndisc = 0;
  integer seed = 32'h0ca2;
  always #4 clk = ~clk;
  rdmr_range_check uut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .lookup_valid, .dest_addr, .src_port, .verdict_valid, .discard, .redirect_to_host,
    .queue_override_flag, .queue_override_value, .color_override_flag, .color,
    .meter_pointer_valid, .meter_pointer, .meter_pointer_order, .irq);
  rdmr_pipe_model pm (.clk, .arst_n, .req, .req_addr, .req_port, .lookup_valid, .dest_addr,
    .src_port);
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic cmpv(input logic [15:0] g, input logic [15:0] x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED t=%0t verdict got %h exp %h", $time, g, x);
    end
  endtask : cmpv
  task automatic cmpw(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED t=%0t word got %h exp %h", $time, g, x);
    end
  endtask : cmpw
  task automatic wr(input int idx, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= 20'(idx * 4);
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input int idx, input logic [31:0] x);
    rq.push_back(x);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= 20'(idx * 4);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  // Verdict layout: discard, redirect, queue flag+value, color flag+value, meter fields.
  function automatic logic [15:0] pred(input logic [47:0] a, input logic [3:0] p);
    logic [15:0] v;
    logic [127:0] e;
    v = '0;
    for (int i = 0; i < 4; i++) begin
      e = tbl[i];
      if (p < 12 && e[112 + p] && a >= e[47:0] && a <= e[95:48]) begin
        v[15] = v[15] | e[96];
        v[14] = v[14] | e[97];
        if (e[98]) v[13:10] = {1'b1, e[101:99]};
        if (e[104]) v[9:7] = {1'b1, e[103:102]};
        if (e[105]) v[6:0] = {1'b1, e[109:106], e[111:110]};
      end
    end
    if (v[14]) v[15] = 1'b0;
    return v;
  endfunction : pred
  task automatic look(input logic [47:0] a, input logic [3:0] p);
    logic [15:0] v;
    v = pred(a, p);
    vq.push_back(v);
    ndisc += v[15];
    ev = ev | {v[14], v[15]};
    @(posedge clk);
    req <= 1'b1;
    req_addr <= a;
    req_port <= p;
  endtask : look
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) cmpw(reg_rdata, rq.pop_front());
    if (verdict_valid) cmpv({discard, redirect_to_host, queue_override_flag,
      queue_override_value, color_override_flag, color, meter_pointer_valid, meter_pointer,
      meter_pointer_order}, vq.pop_front());
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = TBL_FIRST_IDX; i <= MASK_IDX + 1; i++) rd(i, 32'h0);
    $display("test reset values done");
    for (int r = 0; r < 8; r++) begin
      for (int e = 0; e < 4; e++) begin
        tbl[e][47:0] = 48'(e * 'h40 + ($random(seed) & 'h3f));
        tbl[e][95:48] = tbl[e][47:0] + 48'($random(seed) & 'h7f);
        tbl[e][127:96] = {4'h0, 28'($random(seed))};
        tbl[e][112] = 1'b1;
        for (int w = 0; w < 4; w++) wr(TBL_FIRST_IDX + 4 * e + w, tbl[e][32 * w +: 32]);
      end
      for (int i = 0; i < 16; i++) rd(TBL_FIRST_IDX + i, tbl[i / 4][32 * (i % 4) +: 32]);
      for (int e = 0; e < 4; e++) begin
        look(tbl[e][47:0] - 48'h1, 4'h0);
        look(tbl[e][47:0], 4'h0);
        look(tbl[e][95:48], 4'h0);
        look(tbl[e][95:48] + 48'h1, 4'h0);
      end
      repeat (40) look(48'($random(seed) & 'h1ff), 4'($random(seed)));
      @(posedge clk);
      req <= 1'b0;
      repeat (3) @(posedge clk);
    end
    $display("test lookups done");
    cmpw({31'h0, irq}, 32'h0);
    rd(CNT_IDX, 32'(ndisc));
    rd(STAT_IDX, {30'h0, ev});
    wr(MASK_IDX, 32'h3);
    rd(MASK_IDX, 32'h3);
    #1 cmpw({31'h0, irq}, {31'h0, |ev});
    wr(STAT_IDX, 32'h3);
    repeat (2) @(posedge clk);
    #1 cmpw({31'h0, irq}, 32'h0);
    rd(STAT_IDX, 32'h0);
    repeat (3) @(posedge clk);
    $display("test counter and interrupt done");
    conclude();
  end
endmodule : rdmr_range_check_test

// File: rtl/rdmr_pkg.sv
// ==========================================================================
// Shared constants of the reserved destination address range check.
// ==========================================================================
package rdmr_pkg;

  // ========================================================================
  // Geometry of the range table.
  // ========================================================================
  localparam int NUM_ENTRIES = 4;
  localparam int WORDS_PER_ENTRY = 4;
  localparam int DATA_W = 32;
  localparam int ENTRY_STORE_W = 128;
  localparam int ENTRY_W = 124;
  localparam int MAC_W = 48;
  localparam int IDX_W = 18;

  // ========================================================================
  // Register indices; the byte address is four times the index.
  // ========================================================================
  localparam logic [IDX_W-1:0] TBL_FIRST_IDX = 18'h1469a;
  localparam logic [IDX_W-1:0] TBL_LAST_IDX = 18'h146a9;
  localparam logic [IDX_W-1:0] CNT_IDX = 18'h146aa;
  localparam logic [IDX_W-1:0] STAT_IDX = 18'h146ab;
  localparam logic [IDX_W-1:0] MASK_IDX = 18'h146ac;

  // ========================================================================
  // Field positions inside one range entry.
  // ========================================================================
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 48;
  localparam int DISCARD_BIT = 96;
  localparam int REDIRECT_BIT = 97;
  localparam int QFLAG_BIT = 98;
  localparam int QVAL_LSB = 99;
  localparam int QVAL_W = 3;
  localparam int COLOR_LSB = 102;
  localparam int COLOR_W = 2;
  localparam int CFLAG_BIT = 104;
  localparam int MVALID_BIT = 105;
  localparam int MPTR_LSB = 106;
  localparam int MPTR_W = 4;
  localparam int MORDER_LSB = 110;
  localparam int MORDER_W = 2;
  localparam int PEN_LSB = 112;

  // ========================================================================
  // Event status bits and reset values.
  // ========================================================================
  localparam int EV_W = 2;
  localparam int EV_DISCARD = 0;
  localparam int EV_REDIRECT = 1;
  localparam logic [ENTRY_STORE_W-1:0] ENTRY_RESET = 128'h0;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;

endpackage : rdmr_pkg

// File: rtl/rdmr_range_check.sv
`timescale 1ns/1ps

module rdmr_range_check #(
  parameter int ADDR_W = 20,
  parameter int NUM_PORTS = 12,
  parameter int PORT_W = 4,
  parameter int CNT_W = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [rdmr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rdmr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic lookup_valid,
  input wire logic [rdmr_pkg::MAC_W-1:0] dest_addr,
  input wire logic [PORT_W-1:0] src_port,
  output logic verdict_valid,
  output logic discard,
  output logic redirect_to_host,
  output logic queue_override_flag,
  output logic [rdmr_pkg::QVAL_W-1:0] queue_override_value,
  output logic color_override_flag,
  output logic [rdmr_pkg::COLOR_W-1:0] color,
  output logic meter_pointer_valid,
  output logic [rdmr_pkg::MPTR_W-1:0] meter_pointer,
  output logic [rdmr_pkg::MORDER_W-1:0] meter_pointer_order,
  output logic irq
);
  import rdmr_pkg::*;

  // ========================================================================
  // State.
  // ========================================================================
  typedef struct packed {
    logic [NUM_ENTRIES-1:0][ENTRY_STORE_W-1:0] tbl;
    logic [CNT_W-1:0] cnt;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic [DATA_W-1:0] rdata;
    logic vld;
    logic disc;
    logic redir;
    logic qflag;
    logic [QVAL_W-1:0] qval;
    logic cflag;
    logic [COLOR_W-1:0] color;
    logic mvalid;
    logic [MPTR_W-1:0] mptr;
    logic [MORDER_W-1:0] morder;
    logic irq;
  } rdmr_state_t;

  rdmr_state_t st;
  rdmr_state_t next_st;

  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] rel;
  logic in_tbl;
  logic [DATA_W-1:0] tbl_word;
  logic [NUM_ENTRIES-1:0] hit;
  logic [ENTRY_STORE_W-1:0] ent;
  logic [NUM_PORTS-1:0] pen;
  logic any_disc;
  logic any_redir;
  logic [EV_W-1:0] ev;

  assign idx = reg_addr[ADDR_W-1:2];
  assign rel = idx - TBL_FIRST_IDX;
  assign in_tbl = (idx >= TBL_FIRST_IDX) && (idx <= TBL_LAST_IDX);
  // Every entry is visible at once, so a read just picks one word of it.
  assign tbl_word = st.tbl[rel[3:2]][rel[1:0]*DATA_W +: DATA_W];

  // ========================================================================
  // Next-state logic.
  // ========================================================================
  always_comb begin
    next_st = st;
    hit = '0;
    ent = '0;
    pen = '0;
    any_disc = 1'b0;
    any_redir = 1'b0;
    ev = '0;

    // Lookup: entries are walked upward, so a later hit overwrites the
    // forced values of an earlier one and the highest index wins.
    next_st.vld = lookup_valid;
    next_st.qflag = 1'b0;
    next_st.qval = '0;
    next_st.cflag = 1'b0;
    next_st.color = '0;
    next_st.mvalid = 1'b0;
    next_st.mptr = '0;
    next_st.morder = '0;
    for (int e = 0; e < NUM_ENTRIES; e++) begin
      ent = st.tbl[e];
      pen = ent[PEN_LSB +: NUM_PORTS];
      hit[e] = lookup_valid && (int'(src_port) < NUM_PORTS) && pen[src_port]
        && (dest_addr >= ent[LOW_LSB +: MAC_W])
        && (dest_addr <= ent[HIGH_LSB +: MAC_W]);
      if (hit[e]) begin
        any_disc = any_disc | ent[DISCARD_BIT];
        any_redir = any_redir | ent[REDIRECT_BIT];
        if (ent[QFLAG_BIT]) begin
          next_st.qflag = 1'b1;
          next_st.qval = ent[QVAL_LSB +: QVAL_W];
        end
        if (ent[CFLAG_BIT]) begin
          next_st.cflag = 1'b1;
          next_st.color = ent[COLOR_LSB +: COLOR_W];
        end
        if (ent[MVALID_BIT]) begin
          next_st.mvalid = 1'b1;
          next_st.mptr = ent[MPTR_LSB +: MPTR_W];
          next_st.morder = ent[MORDER_LSB +: MORDER_W];
        end
      end
    end
    next_st.redir = any_redir;
    next_st.disc = any_disc && !any_redir;
    if (next_st.disc) begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
    ev[EV_DISCARD] = next_st.disc;
    ev[EV_REDIRECT] = next_st.redir;

    // Register writes. Bits above the entry width are held at zero.
    if (reg_wr) begin
      if (in_tbl) begin
        next_st.tbl[rel[3:2]][rel[1:0]*DATA_W +: DATA_W] = reg_wdata;
        next_st.tbl[rel[3:2]][ENTRY_STORE_W-1:ENTRY_W] = '0;
      end else if (idx == STAT_IDX) begin
        next_st.stat = st.stat & ~reg_wdata[EV_W-1:0];
      end else if (idx == MASK_IDX) begin
        next_st.mask = reg_wdata[EV_W-1:0];
      end
    end
    // A new event in the cycle of its clear survives the clear.
    next_st.stat = next_st.stat | ev;
    next_st.irq = |(next_st.stat & next_st.mask);

    // Read data stand only in the cycle after the strobe; unmapped reads zero.
    next_st.rdata = '0;
    if (reg_rd) begin
      if (in_tbl) begin
        next_st.rdata = tbl_word;
      end else if (idx == CNT_IDX) begin
        next_st.rdata = DATA_W'(st.cnt);
      end else if (idx == STAT_IDX) begin
        next_st.rdata = DATA_W'(st.stat);
      end else if (idx == MASK_IDX) begin
        next_st.rdata = DATA_W'(st.mask);
      end
    end
  end

  // ========================================================================
  // State register.
  // ========================================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // A zero table has every port enable clear, so nothing is checked.
      st <= '{tbl: {NUM_ENTRIES{ENTRY_RESET}}, stat: EV_RESET, mask: EV_RESET,
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign verdict_valid = st.vld;
  assign discard = st.disc;
  assign redirect_to_host = st.redir;
  assign queue_override_flag = st.qflag;
  assign queue_override_value = st.qval;
  assign color_override_flag = st.cflag;
  assign color = st.color;
  assign meter_pointer_valid = st.mvalid;
  assign meter_pointer = st.mptr;
  assign meter_pointer_order = st.morder;
  assign irq = st.irq;

  // ========================================================================
  // Checks.
  // ========================================================================
  below_all_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid && (dest_addr < st.tbl[0][LOW_LSB +: MAC_W])
    && (dest_addr < st.tbl[1][LOW_LSB +: MAC_W])
    && (dest_addr < st.tbl[2][LOW_LSB +: MAC_W])
    && (dest_addr < st.tbl[3][LOW_LSB +: MAC_W]) && !reg_wr
    |=> !discard && !redirect_to_host && !queue_override_flag)
    else $error("verdict raised for an address below every range");

  verdict_timing_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid |=> verdict_valid ##1 ($past(lookup_valid) == verdict_valid))
    else $error("verdict did not follow the lookup by one cycle");

  discard_any_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid && |(hit & {st.tbl[3][DISCARD_BIT], st.tbl[2][DISCARD_BIT],
      st.tbl[1][DISCARD_BIT], st.tbl[0][DISCARD_BIT]})
    |=> discard || redirect_to_host)
    else $error("matching discard entry did not discard");

  discard_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    discard |-> st.cnt == $past(st.cnt) + CNT_W'(1))
    else $error("discard counter did not step by one");

  redirect_wins_a: assert property (@(posedge clk) disable iff (!arst_n)
    redirect_to_host |-> !discard)
    else $error("discard reported alongside redirect");

  queue_highest_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid && hit[3] && st.tbl[3][QFLAG_BIT]
    |=> queue_override_flag && queue_override_value == $past(st.tbl[3][QVAL_LSB +: QVAL_W]))
    else $error("highest matching queue override not taken");

  queue_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    !queue_override_flag |-> queue_override_value == '0)
    else $error("queue value driven without override flag");

  color_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid && hit[0] && st.tbl[0][CFLAG_BIT] && hit[3:1] == '0
    |=> color_override_flag && color == $past(st.tbl[0][COLOR_LSB +: COLOR_W]))
    else $error("matching color override not applied");

  meter_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    !meter_pointer_valid |-> meter_pointer == '0 && meter_pointer_order == '0)
    else $error("meter pointer driven without valid");

  port_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid && (int'(src_port) < NUM_PORTS)
    && !st.tbl[0][PEN_LSB + int'(src_port)] && !st.tbl[1][PEN_LSB + int'(src_port)]
    && !st.tbl[2][PEN_LSB + int'(src_port)] && !st.tbl[3][PEN_LSB + int'(src_port)]
    |=> !discard && !redirect_to_host && !color_override_flag && !meter_pointer_valid)
    else $error("entry acted on a port with its enable clear");

  table_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && in_tbl |=> reg_rdata == $past(tbl_word))
    else $error("table read returned the wrong word");

  irq_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    irq == |(st.stat & st.mask))
    else $error("interrupt does not follow masked status");

  // ========================================================================
  // Checks on the quiet state of the outputs.
  // ========================================================================
  // Downstream stages may latch the fields without looking at the valid, so
  // every field must read zero between verdicts.
  verdict_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !verdict_valid |-> !discard && !redirect_to_host && !queue_override_flag
    && !color_override_flag && !meter_pointer_valid)
    else $error("verdict field raised without a verdict");

  color_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    !color_override_flag |-> color == '0)
    else $error("color driven without override flag");

  // Nothing but a discard verdict may move the counter, or software totals drift.
  count_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !discard |-> st.cnt == $past(st.cnt))
    else $error("discard counter moved without a discard");

  // Reset leaves the table empty and every output low before the first lookup.
  reset_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n) |-> st.tbl == '0 && st.cnt == '0 && st.stat == '0 && st.mask == '0
    && !verdict_valid && !irq && reg_rdata == '0)
    else $error("state not cleared by reset");

  // ========================================================================
  // Checks on the combined actions of the matching entries.
  // ========================================================================
  redirect_any_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid && |(hit & {st.tbl[3][REDIRECT_BIT], st.tbl[2][REDIRECT_BIT],
      st.tbl[1][REDIRECT_BIT], st.tbl[0][REDIRECT_BIT]})
    |=> redirect_to_host && !discard)
    else $error("matching redirect entry did not redirect");

  discard_none_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid && !(|(hit & {st.tbl[3][DISCARD_BIT], st.tbl[2][DISCARD_BIT],
      st.tbl[1][DISCARD_BIT], st.tbl[0][DISCARD_BIT]}))
    |=> !discard)
    else $error("discard raised with no matching discard entry");

  queue_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid && !(|(hit & {st.tbl[3][QFLAG_BIT], st.tbl[2][QFLAG_BIT],
      st.tbl[1][QFLAG_BIT], st.tbl[0][QFLAG_BIT]}))
    |=> !queue_override_flag)
    else $error("queue forced with no matching override flag");

  meter_highest_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid && hit[3] && st.tbl[3][MVALID_BIT]
    |=> meter_pointer_valid && meter_pointer == $past(st.tbl[3][MPTR_LSB +: MPTR_W])
    && meter_pointer_order == $past(st.tbl[3][MORDER_LSB +: MORDER_W]))
    else $error("highest matching meter pointer not taken");

  // Ports beyond the mask width have no enable bit, so they can never match.
  port_range_a: assert property (@(posedge clk) disable iff (!arst_n)
    lookup_valid && (int'(src_port) >= NUM_PORTS)
    |=> !discard && !redirect_to_host && !queue_override_flag && !color_override_flag
    && !meter_pointer_valid)
    else $error("lookup from a port outside the enable mask acted");

  // ========================================================================
  // Checks on the register side.
  // ========================================================================
  table_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    reg_wr && in_tbl && rel == '0 |=> st.tbl[0][DATA_W-1:0] == $past(reg_wdata))
    else $error("table write did not land");

  pad_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    st.tbl[0][ENTRY_STORE_W-1:ENTRY_W] == '0 && st.tbl[1][ENTRY_STORE_W-1:ENTRY_W] == '0
    && st.tbl[2][ENTRY_STORE_W-1:ENTRY_W] == '0 && st.tbl[3][ENTRY_STORE_W-1:ENTRY_W] == '0)
    else $error("bits above the entry width were stored");

  // Read data must fall back to zero, or a slow master could take a stale word.
  read_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data stood without a read");

  count_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && idx == CNT_IDX |=> reg_rdata == DATA_W'($past(st.cnt)))
    else $error("counter read returned the wrong value");

  // Events are sticky: the status bit stands from the verdict that raised it.
  discard_event_a: assert property (@(posedge clk) disable iff (!arst_n)
    discard |-> st.stat[EV_DISCARD])
    else $error("discard event not recorded");

  redirect_event_a: assert property (@(posedge clk) disable iff (!arst_n)
    redirect_to_host |-> st.stat[EV_REDIRECT])
    else $error("redirect event not recorded");

endmodule : rdmr_range_check
